// >>> verilog/afepc_top.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - sink current only while front-end enable is high
// - emitter A alone with battery test off selects path A, base plus code, scale set by doubling bit
// - doubling bit set gives doubled base and doubled step
// - emitter B alone with battery test off selects path B, base plus code
// - battery test with emitter A alone sinks load code from battery pin
// - every other enable combination selects no path
// - both enables high over 25 us sets soft-reset flag
// - doubling control is bit 0 of register index 0x0a
// - converter off: select pin low picks diode 1, high diode 2
// - converter on: per-sample configuration picks the diode
// - open-input bit disconnects both diodes
// - gain and input-stage fields each select one of four values
// - each channel has its own 8-bit offset code
// - direction low: hv driver off, received level out on transceive pin
// - direction high: transceive pin level drives hv output
// - direction input defaults to receive when floating
// - ready rises within 50 us of front-end enable rising
module afepc_top #(
    parameter int OVERLAP_CYCLES = afepc_pkg::OVERLAP_CYC,
    parameter int WAKE_CYCLES = afepc_pkg::WAKE_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic frontend_enable,
    input wire logic emitter_a_enable,
    input wire logic emitter_b_enable,
    input wire logic diode_select,
    input wire logic io_direction,
    input wire logic transceive_pin_i,
    output logic transceive_pin_o,
    output logic transceive_pin_oe,
    input wire logic hv_line_in,
    output logic hv_line_out,
    output logic hv_line_out_oe,
    output logic frontend_ready,
    output logic soft_reset_flag,
    output afepc_pkg::afepc_sink_s sink,
    output logic diode1_connect,
    output logic diode2_connect,
    output logic [1:0] amp_gain_select,
    output logic [1:0] input_stage_gain,
    output logic [7:0] channel_a_offset_comp,
    output logic [7:0] channel_b_offset_comp
);

    typedef struct packed {
        afepc_pkg::afepc_pins_s s1;
        afepc_pkg::afepc_pins_s s2;
        logic dsel_d;
        logic [7:0] code_a;
        logic [7:0] code_b;
        logic [7:0] code_batt;
        logic dbl;
        logic batt_en;
        logic conv_en;
        logic open_in;
        logic [1:0] gain;
        logic [1:0] istage;
        logic [7:0] comp_a;
        logic [7:0] comp_b;
        logic [7:0] per_sample_config;
        logic [2:0] sample_idx;
        logic [15:0] ovl_cnt;
        logic [15:0] wake_cnt;
        logic ready;
        logic srst_flag;
        afepc_pkg::afepc_sink_s sink;
        logic d1;
        logic d2;
        logic tx_o;
        logic tx_oe;
        logic hv_o;
        logic hv_oe;
        logic [31:0] rdata;
        logic ack;
    } afepc_state_s;

    afepc_state_s st_reg;
    afepc_state_s st_next;

    logic wb_req;
    logic [31:0] rd_mux;
    logic [31:0] wmask;
    logic [31:0] wval;
    afepc_pkg::afepc_path_e path_sel;
    logic pd2_pick;

    assign wb_req = wb_cyc_i && wb_stb_i && !st_reg.ack;

    // byte-lane mask for writes
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[8*i +: 8] = {8{wb_sel_i[i]}};
        end
    end

    // read decode, unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0;
        case (wb_adr_i)
            afepc_pkg::ADDR_EMIT_A: rd_mux = {24'h0, st_reg.code_a};
            afepc_pkg::ADDR_EMIT_B: rd_mux = {24'h0, st_reg.code_b};
            afepc_pkg::ADDR_BATT_LOAD: rd_mux = {24'h0, st_reg.code_batt};
            afepc_pkg::ADDR_CTRL: rd_mux = {29'h0, st_reg.open_in, st_reg.conv_en, st_reg.batt_en};
            afepc_pkg::ADDR_TIA: rd_mux = {28'h0, st_reg.istage, st_reg.gain};
            afepc_pkg::ADDR_COMP_A: rd_mux = {24'h0, st_reg.comp_a};
            afepc_pkg::ADDR_COMP_B: rd_mux = {24'h0, st_reg.comp_b};
            afepc_pkg::ADDR_SAMPLE: rd_mux = {24'h0, st_reg.per_sample_config};
            afepc_pkg::ADDR_STATUS: rd_mux = {26'h0, st_reg.sample_idx, 1'b0, st_reg.ready, st_reg.srst_flag};
            afepc_pkg::ADDR_LED_CFG: rd_mux = {31'h0, st_reg.dbl};
            default: rd_mux = 32'h0;
        endcase
    end

    // decode of the synchronised enables into one path
    always_comb begin
        path_sel = afepc_pkg::AFEPC_PATH_NONE;
        if (st_reg.s2.fe_en) begin
            case ({st_reg.batt_en, st_reg.s2.em_b, st_reg.s2.em_a})
                3'b001: path_sel = afepc_pkg::AFEPC_PATH_A;
                3'b010: path_sel = afepc_pkg::AFEPC_PATH_B;
                3'b101: path_sel = afepc_pkg::AFEPC_PATH_BATT;
                default: path_sel = afepc_pkg::AFEPC_PATH_NONE;
            endcase
        end
    end

    // diode choice: pin when converter off, sample table when on
    always_comb begin
        if (st_reg.conv_en) begin
            pd2_pick = st_reg.per_sample_config[st_reg.sample_idx];
        end else begin
            pd2_pick = st_reg.s2.dsel;
        end
    end

    // next-state logic
    always_comb begin
        st_next = st_reg;
        // two-stage synchroniser of all pins
        st_next.s1 = '{frontend_enable, emitter_a_enable, emitter_b_enable, diode_select,
                       io_direction, transceive_pin_i, hv_line_in};
        st_next.s2 = st_reg.s1;
        st_next.dsel_d = st_reg.s2.dsel;
        // bus slave, one wait state then ack
        st_next.ack = wb_req;
        st_next.rdata = wb_req ? rd_mux : 32'h0;
        wval = 32'h0;
        if (wb_req && wb_we_i) begin
            case (wb_adr_i)
                afepc_pkg::ADDR_EMIT_A: st_next.code_a = wb_dat_i[7:0] & wmask[7:0] | st_reg.code_a & ~wmask[7:0];
                afepc_pkg::ADDR_EMIT_B: st_next.code_b = wb_dat_i[7:0] & wmask[7:0] | st_reg.code_b & ~wmask[7:0];
                afepc_pkg::ADDR_BATT_LOAD: st_next.code_batt = wb_dat_i[7:0] & wmask[7:0] | st_reg.code_batt & ~wmask[7:0];
                afepc_pkg::ADDR_CTRL: begin
                    if (wb_sel_i[0]) begin
                        st_next.batt_en = wb_dat_i[afepc_pkg::CTRL_BATT_BIT];
                        st_next.conv_en = wb_dat_i[afepc_pkg::CTRL_CONV_BIT];
                        st_next.open_in = wb_dat_i[afepc_pkg::CTRL_OPEN_BIT];
                    end
                end
                afepc_pkg::ADDR_TIA: begin
                    if (wb_sel_i[0]) begin
                        st_next.gain = wb_dat_i[1:0];
                        st_next.istage = wb_dat_i[3:2];
                    end
                end
                afepc_pkg::ADDR_COMP_A: st_next.comp_a = wb_dat_i[7:0] & wmask[7:0] | st_reg.comp_a & ~wmask[7:0];
                afepc_pkg::ADDR_COMP_B: st_next.comp_b = wb_dat_i[7:0] & wmask[7:0] | st_reg.comp_b & ~wmask[7:0];
                afepc_pkg::ADDR_SAMPLE: st_next.per_sample_config = wb_dat_i[7:0] & wmask[7:0] | st_reg.per_sample_config & ~wmask[7:0];
                afepc_pkg::ADDR_STATUS: wval = wb_dat_i;
                afepc_pkg::ADDR_LED_CFG: begin
                    if (wb_sel_i[0]) begin
                        st_next.dbl = wb_dat_i[afepc_pkg::DOUBLE_BIT];
                    end
                end
                default: wval = 32'h0;
            endcase
        end
        // overlap counter, cleared by either enable dropping
        if (st_reg.s2.em_a && st_reg.s2.em_b) begin
            if (st_reg.ovl_cnt < 16'(OVERLAP_CYCLES)) begin
                st_next.ovl_cnt = st_reg.ovl_cnt + 16'h1;
            end
        end else begin
            st_next.ovl_cnt = 16'h0;
        end
        // soft-reset flag: write one clears, a new set wins
        if (wb_sel_i[0] && wval[afepc_pkg::STAT_SRST_BIT]) begin
            st_next.srst_flag = 1'b0;
        end
        if (st_reg.ovl_cnt == 16'(OVERLAP_CYCLES - 1) && st_reg.s2.em_a && st_reg.s2.em_b) begin
            st_next.srst_flag = 1'b1;
        end
        // wake timer and ready
        if (!st_reg.s2.fe_en) begin
            st_next.wake_cnt = 16'h0;
            st_next.ready = 1'b0;
            st_next.sample_idx = 3'h0;
        end else if (!st_reg.ready) begin
            st_next.wake_cnt = st_reg.wake_cnt + 16'h1;
            if (st_reg.wake_cnt == 16'(WAKE_CYCLES - 4)) begin
                st_next.ready = 1'b1;
            end
        end
        // each diode-select rising edge while the front end and converter are on advances the sample slot; the edge comes
        // from the second sync stage and its delayed copy, never the first stage
        if (st_reg.s2.fe_en && st_reg.conv_en && st_reg.s2.dsel && !st_reg.dsel_d) begin
            st_next.sample_idx = st_reg.sample_idx + 3'h1;
        end
        // registered sink outputs, base and step doubled together
        st_next.sink.path = path_sel;
        st_next.sink.code = (path_sel == afepc_pkg::AFEPC_PATH_A) ? st_reg.code_a :
                            (path_sel == afepc_pkg::AFEPC_PATH_B) ? st_reg.code_b :
                            (path_sel == afepc_pkg::AFEPC_PATH_BATT) ? st_reg.code_batt : 8'h00;
        st_next.sink.base = (path_sel == afepc_pkg::AFEPC_PATH_A) || (path_sel == afepc_pkg::AFEPC_PATH_B);
        st_next.sink.dbl = st_reg.dbl && (path_sel != afepc_pkg::AFEPC_PATH_NONE);
        // diode routing
        st_next.d1 = st_reg.s2.fe_en && !st_reg.open_in && !pd2_pick;
        st_next.d2 = st_reg.s2.fe_en && !st_reg.open_in && pd2_pick;
        // level translator direction
        st_next.tx_oe = !st_reg.s2.iodir;
        st_next.tx_o = !st_reg.s2.iodir && st_reg.s2.hv_in;
        st_next.hv_oe = st_reg.s2.iodir;
        st_next.hv_o = st_reg.s2.iodir && st_reg.s2.transceive_pin;
    end

    // single state register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_o = st_reg.rdata;
    assign wb_ack_o = st_reg.ack;
    assign transceive_pin_o = st_reg.tx_o;
    assign transceive_pin_oe = st_reg.tx_oe;
    assign hv_line_out = st_reg.hv_o;
    assign hv_line_out_oe = st_reg.hv_oe;
    assign frontend_ready = st_reg.ready;
    assign soft_reset_flag = st_reg.srst_flag;
    assign sink = st_reg.sink;
    assign diode1_connect = st_reg.d1;
    assign diode2_connect = st_reg.d2;
    assign amp_gain_select = st_reg.gain;
    assign input_stage_gain = st_reg.istage;
    assign channel_a_offset_comp = st_reg.comp_a;
    assign channel_b_offset_comp = st_reg.comp_b;

    // helper: cycles since enable rose
    logic [15:0] since_rise;
    always_ff @(posedge sys_clk) begin
        if (srst || !st_reg.s2.fe_en) begin
            since_rise <= 16'h0;
        end else if (since_rise != 16'hffff) begin
            since_rise <= since_rise + 16'h1;
        end
    end

    no_sink_off_a: assert property (@(posedge sys_clk) disable iff (srst)
        !st_reg.s2.fe_en |=> sink.path == afepc_pkg::AFEPC_PATH_NONE)
        else $error("sink active with front end off");

    path_a_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
        st_reg.s2.fe_en && !st_reg.batt_en && st_reg.s2.em_a && !st_reg.s2.em_b
        |=> sink.path == afepc_pkg::AFEPC_PATH_A && sink.code == $past(st_reg.code_a) && sink.base)
        else $error("emitter a path wrong");

    double_scale_a: assert property (@(posedge sys_clk) disable iff (srst)
        path_sel != afepc_pkg::AFEPC_PATH_NONE |=> sink.dbl == $past(st_reg.dbl))
        else $error("doubling not applied");

    path_b_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
        st_reg.s2.fe_en && !st_reg.batt_en && !st_reg.s2.em_a && st_reg.s2.em_b
        |=> sink.path == afepc_pkg::AFEPC_PATH_B && sink.code == $past(st_reg.code_b))
        else $error("emitter b path wrong");

    batt_path_a: assert property (@(posedge sys_clk) disable iff (srst)
        st_reg.s2.fe_en && st_reg.batt_en && st_reg.s2.em_a && !st_reg.s2.em_b
        |=> sink.path == afepc_pkg::AFEPC_PATH_BATT && !sink.base)
        else $error("battery path wrong");

    both_high_none_a: assert property (@(posedge sys_clk) disable iff (srst)
        st_reg.s2.em_a && st_reg.s2.em_b |=> sink.path == afepc_pkg::AFEPC_PATH_NONE)
        else $error("path selected with both enables");

    sequence overlap_held_s;
        st_reg.s2.em_a && st_reg.s2.em_b && st_reg.ovl_cnt == 16'(OVERLAP_CYCLES - 1);
    endsequence
    soft_reset_set_a: assert property (@(posedge sys_clk) disable iff (srst)
        overlap_held_s |=> soft_reset_flag)
        else $error("soft reset not raised");

    overlap_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
        !(st_reg.s2.em_a && st_reg.s2.em_b) |=> st_reg.ovl_cnt == 16'h0)
        else $error("overlap counter not cleared");

    open_input_a: assert property (@(posedge sys_clk) disable iff (srst)
        st_reg.open_in |=> !diode1_connect && !diode2_connect)
        else $error("diode connected while open");

    pin_pick_a: assert property (@(posedge sys_clk) disable iff (srst)
        st_reg.s2.fe_en && !st_reg.conv_en && !st_reg.open_in && st_reg.s2.dsel
        |=> diode2_connect && !diode1_connect)
        else $error("pin diode choice wrong");

    slot_pick_a: assert property (@(posedge sys_clk) disable iff (srst)
        st_reg.s2.fe_en && st_reg.conv_en && !st_reg.open_in && !st_reg.per_sample_config[st_reg.sample_idx]
        |=> diode1_connect && !diode2_connect)
        else $error("slot diode choice wrong");

    tx_dir_a: assert property (@(posedge sys_clk) disable iff (srst)
        st_reg.s2.iodir |=> hv_line_out_oe && !transceive_pin_oe && hv_line_out == $past(st_reg.s2.transceive_pin))
        else $error("transmit direction wrong");

    rx_dir_a: assert property (@(posedge sys_clk) disable iff (srst)
        !st_reg.s2.iodir |=> transceive_pin_oe && !hv_line_out_oe
        && transceive_pin_o == $past(st_reg.s2.hv_in))
        else $error("receive direction wrong");

    ready_time_a: assert property (@(posedge sys_clk) disable iff (srst)
        since_rise == 16'(WAKE_CYCLES) |-> frontend_ready)
        else $error("ready late");

    ready_drop_a: assert property (@(posedge sys_clk) disable iff (srst)
        !st_reg.s2.fe_en |=> !frontend_ready)
        else $error("ready high with front end off");

endmodule

`default_nettype wire

// >>> common/afepc_pkg.sv
`default_nettype none
package afepc_pkg;

    // register byte addresses (word aligned), plus the LED config word index
    localparam logic [7:0] ADDR_LED_CFG = 8'h28;
    localparam logic [7:0] ADDR_EMIT_A = 8'h00;
    localparam logic [7:0] ADDR_EMIT_B = 8'h04;
    localparam logic [7:0] ADDR_BATT_LOAD = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_TIA = 8'h10;
    localparam logic [7:0] ADDR_COMP_A = 8'h14;
    localparam logic [7:0] ADDR_COMP_B = 8'h18;
    localparam logic [7:0] ADDR_SAMPLE = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] LED_CFG_INDEX = 8'h0a;

    // field positions
    localparam int DOUBLE_BIT = 0;
    localparam int CTRL_BATT_BIT = 0;
    localparam int CTRL_CONV_BIT = 1;
    localparam int CTRL_OPEN_BIT = 2;
    localparam int STAT_SRST_BIT = 0;
    localparam int STAT_READY_BIT = 1;

    // reset values
    localparam logic [7:0] CODE_RESET = 8'h00;
    localparam logic [7:0] SAMPLE_RESET = 8'h00;

    // timing, 100 MHz clock
    localparam int CLK_MHZ = 100;
    localparam int OVERLAP_US = 25;
    localparam int WAKE_US = 50;
    localparam int OVERLAP_CYC = OVERLAP_US * CLK_MHZ;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ - 1;

    // current path selection
    typedef enum logic [1:0] {
        AFEPC_PATH_NONE = 2'b00,
        AFEPC_PATH_A = 2'b01,
        AFEPC_PATH_B = 2'b10,
        AFEPC_PATH_BATT = 2'b11
    } afepc_path_e;

    // synchronised pin group
    typedef struct packed {
        logic fe_en;
        logic em_a;
        logic em_b;
        logic dsel;
        logic iodir;
        logic transceive_pin;
        logic hv_in;
    } afepc_pins_s;

    // sink driver outputs
    typedef struct packed {
        afepc_path_e path;
        logic [7:0] code;
        logic base;
        logic dbl;
    } afepc_sink_s;

endpackage
`default_nettype wire

// >>> verif/afepc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host controller model driving the front-end pins
module afepc_host_model #(
    parameter int GAP_CYC = 100
) (
    input wire logic sys_clk,
    output logic frontend_enable,
    output logic emitter_a_enable,
    output logic emitter_b_enable,
    output logic diode_select,
    output logic io_dir_oe,
    output logic io_dir_drive,
    output logic transceive_pin_drive
);
    // all pins idle low, direction pin released
    initial begin
        frontend_enable = 1'b0;
        emitter_a_enable = 1'b0;
        emitter_b_enable = 1'b0;
        diode_select = 1'b0;
        io_dir_oe = 1'b0;
        io_dir_drive = 1'b0;
        transceive_pin_drive = 1'b0;
    end
    // drop both enables, keep the non-overlap gap, then raise the new pair
    task automatic emit(input logic a, input logic b);
        @(posedge sys_clk);
        emitter_a_enable <= 1'b0;
        emitter_b_enable <= 1'b0;
        repeat (GAP_CYC) @(posedge sys_clk);
        emitter_a_enable <= a; // never both while battery test on
        emitter_b_enable <= b;
    endtask
    // set the level pins in one step
    task automatic drive(input logic fe, input logic ds, input logic oe, input logic dir, input logic tx);
        @(posedge sys_clk);
        frontend_enable <= fe;
        diode_select <= ds;
        io_dir_oe <= oe;
        io_dir_drive <= dir;
        transceive_pin_drive <= tx;
    endtask
endmodule
`default_nettype wire

// >>> verif/afe_pin_control_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
module afe_pin_control_decode_test;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_ack_o, fe, ea, eb, dsel, dir_d, dir_oe, tx_d, txo, txoe, hvo, hvoe, rdy, srf, d1, d2;
    logic hv_bench = 1'b0, flt = 1'b0;
    logic [1:0] gain, istage;
    logic [7:0] ofs_a, ofs_b;
    afepc_pkg::afepc_sink_s sink;
    int error_cnt = 0, tests_run = 0, cyc_cnt = 0;
    // pin levels: weak pull-down on direction, released transceive line toggles
    wire logic dir_w = dir_oe ? dir_d : 1'b0;
    // host owns the transceive pin as soon as its direction pin says transmit
    wire logic tx_w = dir_w ? tx_d : (txoe ? txo : flt);
    wire logic hv_w = hvoe ? hvo : hv_bench;
    afepc_top #(.OVERLAP_CYCLES(20), .WAKE_CYCLES(20)) u_dut (.sys_clk(sys_clk), .srst(srst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .frontend_enable(fe), .emitter_a_enable(ea), .emitter_b_enable(eb), .diode_select(dsel),
        .io_direction(dir_w), .transceive_pin_i(tx_w), .transceive_pin_o(txo), .transceive_pin_oe(txoe),
        .hv_line_in(hv_w), .hv_line_out(hvo), .hv_line_out_oe(hvoe), .frontend_ready(rdy),
        .soft_reset_flag(srf), .sink(sink), .diode1_connect(d1), .diode2_connect(d2),
        .amp_gain_select(gain), .input_stage_gain(istage), .channel_a_offset_comp(ofs_a),
        .channel_b_offset_comp(ofs_b));
    afepc_host_model h (.sys_clk(sys_clk), .frontend_enable(fe), .emitter_a_enable(ea),
        .emitter_b_enable(eb), .diode_select(dsel), .io_dir_oe(dir_oe), .io_dir_drive(dir_d),
        .transceive_pin_drive(tx_d));
    // clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // floating pattern and hang guard
    always @(posedge sys_clk) begin
        flt <= ~flt;
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 10000) begin
            error_cnt++;
            results();
        end
    end
    task automatic chk_b(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_s(input afepc_pkg::afepc_sink_s e, input afepc_pkg::afepc_sink_s g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH sink expected %h seen %h", e, g);
        end
    endtask
    // one classic wishbone cycle, waits for ack
    task automatic wbx(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        chk_b("wb_ack", 1'b1, wb_ack_o);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    // outputs land three edges after a pin change
    task automatic settle;
        repeat (4) @(posedge sys_clk);
    endtask
    // expected sink from {battery, emitter b, emitter a}
    function automatic afepc_pkg::afepc_sink_s exp_sink(input logic [2:0] c, input logic dbl);
        afepc_pkg::afepc_sink_s s;
        s = '0;
        if (c == 3'b001) s = {afepc_pkg::AFEPC_PATH_A, 8'h37, 1'b1, dbl};
        if (c == 3'b010) s = {afepc_pkg::AFEPC_PATH_B, 8'hc8, 1'b1, dbl};
        if (c == 3'b101) s = {afepc_pkg::AFEPC_PATH_BATT, 8'h64, 1'b0, dbl};
        return s;
    endfunction
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        wbx(1'b0, afepc_pkg::ADDR_EMIT_A, 32'h0);
        chk_w("emit_a reset", 32'h0, rd);
        wbx(1'b0, 8'h3c, 32'h0);
        chk_w("unmapped", 32'h0, rd);
        wbx(1'b1, afepc_pkg::ADDR_EMIT_A, 32'h37);
        wbx(1'b1, afepc_pkg::ADDR_EMIT_B, 32'hc8);
        wbx(1'b1, afepc_pkg::ADDR_BATT_LOAD, 32'h64);
        wbx(1'b1, afepc_pkg::ADDR_LED_CFG, 32'h1);
        wbx(1'b0, afepc_pkg::ADDR_LED_CFG, 32'h0);
        chk_w("double", 32'h1, rd);
        $display("test registers done");
        h.emit(1'b1, 1'b0);
        settle();
        chk_s(exp_sink(3'b000, 1'b1), sink);
        h.drive(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        settle();
        chk_b("ready early", 1'b0, rdy);
        repeat (40) @(posedge sys_clk);
        chk_b("ready", 1'b1, rdy);
        $display("test wake done");
        for (int d = 0; d < 2; d++) begin
            wbx(1'b1, afepc_pkg::ADDR_LED_CFG, 32'(d));
            for (int c = 0; c < 7; c++) begin
                // enables move first, so battery test never meets an overlap
                h.emit(c[0], c[1]);
                wbx(1'b1, afepc_pkg::ADDR_CTRL, {31'h0, c[2]});
                settle();
                chk_s(exp_sink(c[2:0], d[0]), sink);
            end
        end
        h.emit(1'b0, 1'b0);
        $display("test decode done");
        wbx(1'b1, afepc_pkg::ADDR_CTRL, 32'h0);
        settle();
        chk_b("diode1", 1'b1, d1);
        chk_b("diode2", 1'b0, d2);
        h.drive(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        settle();
        chk_b("diode1", 1'b0, d1);
        chk_b("diode2", 1'b1, d2);
        wbx(1'b1, afepc_pkg::ADDR_CTRL, 32'h4);
        settle();
        chk_w("open", 32'h0, {30'h0, d1, d2});
        wbx(1'b1, afepc_pkg::ADDR_SAMPLE, 32'h1);
        h.drive(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        wbx(1'b1, afepc_pkg::ADDR_CTRL, 32'h2);
        settle();
        chk_w("sample pick", 32'h1, {30'h0, d1, d2});
        h.drive(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        repeat (5) @(posedge sys_clk);
        chk_w("sample slot", 32'h2, {30'h0, d1, d2});
        wbx(1'b1, afepc_pkg::ADDR_CTRL, 32'h0);
        wbx(1'b1, afepc_pkg::ADDR_TIA, 32'he);
        wbx(1'b1, afepc_pkg::ADDR_COMP_A, 32'hff);
        wbx(1'b1, afepc_pkg::ADDR_COMP_B, 32'h5a);
        settle();
        chk_w("gains", 32'he, {28'h0, istage, gain});
        chk_w("offsets", 32'hff5a, {16'h0, ofs_a, ofs_b});
        wbx(1'b0, afepc_pkg::ADDR_COMP_B, 32'h0);
        chk_w("offset b", 32'h5a, rd);
        $display("test diode done");
        for (int v = 0; v < 2; v++) begin
            @(posedge sys_clk) hv_bench <= v[0];
            settle();
            chk_w("receive", {29'h0, 1'b1, 1'b0, v[0]}, {29'h0, txoe, hvoe, txo});
            h.drive(1'b1, 1'b0, 1'b1, 1'b1, ~v[0]);
            settle();
            chk_w("transmit", {29'h0, 1'b0, 1'b1, ~v[0]}, {29'h0, txoe, hvoe, hvo});
            h.drive(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        end
        $display("test gpio done");
        h.emit(1'b1, 1'b1);
        repeat (10) @(posedge sys_clk);
        h.emit(1'b1, 1'b1);
        repeat (12) @(posedge sys_clk);
        chk_b("soft reset", 1'b0, srf);
        repeat (30) @(posedge sys_clk);
        chk_b("soft reset", 1'b1, srf);
        wbx(1'b0, afepc_pkg::ADDR_STATUS, 32'h0);
        chk_b("status flag", 1'b1, rd[afepc_pkg::STAT_SRST_BIT]);
        h.emit(1'b0, 1'b0);
        wbx(1'b1, afepc_pkg::ADDR_STATUS, 32'h1);
        wbx(1'b0, afepc_pkg::ADDR_STATUS, 32'h0);
        chk_b("status clear", 1'b0, rd[afepc_pkg::STAT_SRST_BIT]);
        $display("test overlap done");
        results();
    end
endmodule
`default_nettype wire
